// file: src/rmrx_consts.vh
`ifndef RMRX_CONSTS_VH
`define RMRX_CONSTS_VH

// ==========================================================
// Register addresses
`define RMRX_ADDR_CTRL 16'hFF60
`define RMRX_ADDR_GPHS 16'hFF61
`define RMRX_ADDR_GPHL 16'hFF62
`define RMRX_ADDR_DLS 16'hFF63
`define RMRX_ADDR_DLL 16'hFF64
`define RMRX_ADDR_DH0S 16'hFF65
`define RMRX_ADDR_DH0L 16'hFF66
`define RMRX_ADDR_DH1S 16'hFF67
`define RMRX_ADDR_DH1L 16'hFF68
`define RMRX_ADDR_ER 16'hFF69
`define RMRX_ADDR_SR 16'hFF6A
`define RMRX_ADDR_SCR 16'hFF6B
`define RMRX_ADDR_DR 16'hFF6C

// ==========================================================
// Control register fields
`define RMRX_CTRL_EN 7
`define RMRX_CTRL_NOISE 6
`define RMRX_CTRL_HALVE 5
`define RMRX_CTRL_INV 4
`define RMRX_CTRL_SEL_HI 1
`define RMRX_CTRL_SEL_LO 0
`define RMRX_CTRL_MASK 8'hF3

// ==========================================================
// Reset values and limits
`define RMRX_REG_RST 8'h00
`define RMRX_CNT_MAX 8'hFF
`define RMRX_BIT_LAST 8'h07
`define RMRX_PRE_RST 8'h00

// ==========================================================
// Source clock selection and prescaler terminal masks
`define RMRX_SRC_DIV64 2'h0
`define RMRX_SRC_DIV128 2'h1
`define RMRX_SRC_DIV256 2'h2
`define RMRX_SRC_SUB 2'h3
`define RMRX_PRE_END64 6'h3F
`define RMRX_PRE_END128 7'h7F
`define RMRX_PRE_END256 8'hFF

`endif

// file: src/rmrx_cond.v
`timescale 1ns/1ps
`include "rmrx_consts.vh"

module rmrx_cond
(
  // Clock and reset
  input wire i_clk,
  input wire i_reset,
  // Configuration
  input wire i_run,
  input wire [1:0] i_src_sel,
  input wire i_halve,
  input wire i_invert,
  input wire i_noise_wide,
  // Line inputs
  input wire i_pin,
  input wire i_sub_clk,
  // Conditioned outputs
  output reg o_tick,
  output reg o_level
);

  reg [7:0] pre_q;
  reg sub_q;
  reg half_q;
  reg smp0_q;
  reg smp1_q;
  reg smp2_q;
  reg src_tick;
  wire tick_d;

  // ==========================================================
  // Source clock selection
  always @*
  begin
    case (i_src_sel)
      `RMRX_SRC_DIV64: src_tick = (pre_q[5:0] == `RMRX_PRE_END64);
      `RMRX_SRC_DIV128: src_tick = (pre_q[6:0] == `RMRX_PRE_END128);
      `RMRX_SRC_DIV256: src_tick = (pre_q == `RMRX_PRE_END256);
      default: src_tick = i_sub_clk & ~sub_q; // Rising edge of slow oscillator
    endcase
  end

  // Halving passes every second source tick
  assign tick_d = src_tick & (~i_halve | half_q);

  // ==========================================================
  // Prescaler, halving phase and tick
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      pre_q <= `RMRX_PRE_RST;
      sub_q <= 1'b0;
      half_q <= 1'b0;
      o_tick <= 1'b0;
    end
    else
    begin
      pre_q <= pre_q + 8'h01;
      sub_q <= i_sub_clk;
      if (src_tick)
        half_q <= ~half_q;
      o_tick <= tick_d & i_run;
    end
  end

  // ==========================================================
  // Sampling filter; a level is accepted only when samples agree
  always @(posedge i_clk)
  begin
    if (i_reset || !i_run)
    begin
      smp0_q <= 1'b0;
      smp1_q <= 1'b0;
      smp2_q <= 1'b0;
      o_level <= 1'b0;
    end
    else if (tick_d)
    begin
      smp0_q <= i_pin ^ i_invert;
      smp1_q <= smp0_q;
      smp2_q <= smp1_q;
      if (!i_noise_wide && smp0_q == smp1_q)
        o_level <= smp0_q;
      else if (i_noise_wide && smp0_q == smp1_q && smp1_q == smp2_q)
        o_level <= smp0_q;
    end
  end

endmodule // rmrx_cond

// file: src/rmrx_top.v
`timescale 1ns/1ps
`include "rmrx_consts.vh"

// Functional notes
// - Data-one high upper bound register, 8 bits, resets to 00H.
// - End-width register sets low time before frame end; resets to 00H.
// - Control bit 7 enables reception when 1, disables when 0.
// - Control bit 6 picks noise reject width of one or two internal clocks.
// - Control bit 5 halves the internal clock when set.
// - Control bit 4 inverts the receive pin when set.
// - Bits 1:0 pick main clock /64, /128, /256 or subsystem oscillator.
// - Control register takes bit and byte writes, reset clears it.
// - Error clears shift register and bit count at once.
// - Full shift register moves to holding register, flags full, clears.
// - Reading shift register after frame end clears it; reception resumes.
// - Clearing enable clears shift, count and holding registers.
// - Guide high width inside window flags guide and starts data.
// - Guide width outside window is ignored; wait for next rising edge.
// - Data low too short flags error and restarts guide measurement.
// - Data low inside window starts data high measurement.
// - Low reaching long bound starts end-width measurement.
// - Data high width picks zero, one, or error by window.
// - End width reached flags frame end and halts until shift read.
// - Bits enter at bit 7 and shift toward bit 0.
// - Error only after a guide pulse, at most once per guide.
module rmrx_top
(
  // Clock and reset
  input wire I_CLK,
  input wire I_RESET,
  // Register access
  input wire [15:0] I_ADDR,
  input wire I_WR,
  input wire [7:0] I_WDATA,
  input wire I_BIT_WR,
  input wire [2:0] I_BIT_SEL,
  input wire I_BIT_VAL,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  // Line inputs
  input wire I_IR_INPUT_PIN,
  input wire I_SUB_CLK,
  // Events
  output reg O_GUIDE_PULSE_EVENT,
  output reg O_BYTE_FULL_EVENT,
  output reg O_FRAME_END_EVENT,
  output reg O_RECEIVE_ERROR_EVENT
);

  // ==========================================================
  // States
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_GUIDE = 3'h1;
  localparam [2:0] ST_DLOW = 3'h2;
  localparam [2:0] ST_DHIGH = 3'h3;
  localparam [2:0] ST_ENDW = 3'h4;
  localparam [2:0] ST_HALT = 3'h5;

  // ==========================================================
  // Registers
  reg [7:0] receive_control_q;
  reg [7:0] guide_high_lower_bound_q;
  reg [7:0] guide_high_upper_bound_q;
  reg [7:0] data_low_lower_bound_q;
  reg [7:0] data_low_upper_bound_q;
  reg [7:0] data_zero_high_lower_bound_q;
  reg [7:0] data_zero_high_upper_bound_q;
  reg [7:0] data_one_high_lower_bound_q;
  reg [7:0] data_one_high_upper_bound_q;
  reg [7:0] end_width_select_q;
  reg [7:0] bit_shift_register_q;
  reg [7:0] valid_bit_count_q;
  reg [7:0] byte_holding_register_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] cnt_q;
  reg level_prev_q;
  reg err_armed_q;

  // Decision terms
  reg err_now;
  reg store_now;
  reg bit_now;
  reg guide_now;
  reg frame_now;
  reg cnt_restart;
  reg [7:0] ctrl_wr_val;

  wire tick;
  wire level;
  wire rise;
  wire fall;
  wire receive_enable;
  wire sr_read;
  wire [7:0] shifted;

  assign receive_enable = receive_control_q[`RMRX_CTRL_EN];
  assign rise = level & ~level_prev_q;
  assign fall = ~level & level_prev_q;
  assign sr_read = I_RD && (I_ADDR == `RMRX_ADDR_SR);
  assign shifted = {bit_now, bit_shift_register_q[7:1]};

  // ==========================================================
  // Input conditioning: clock selection, polarity, noise filter
  rmrx_cond u_cond
  (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_run(receive_enable),
    .i_src_sel({receive_control_q[`RMRX_CTRL_SEL_HI],
                receive_control_q[`RMRX_CTRL_SEL_LO]}),
    .i_halve(receive_control_q[`RMRX_CTRL_HALVE]),
    .i_invert(receive_control_q[`RMRX_CTRL_INV]),
    .i_noise_wide(receive_control_q[`RMRX_CTRL_NOISE]),
    .i_pin(I_IR_INPUT_PIN),
    .i_sub_clk(I_SUB_CLK),
    .o_tick(tick),
    .o_level(level)
  );

  // ==========================================================
  // Control write value; bits 3 and 2 are held at zero so a stray
  // write by software cannot leave them set
  always @*
  begin
    ctrl_wr_val = receive_control_q;
    if (I_BIT_WR)
      ctrl_wr_val[I_BIT_SEL] = I_BIT_VAL;
    else
      ctrl_wr_val = I_WDATA;
    ctrl_wr_val = ctrl_wr_val & `RMRX_CTRL_MASK;
  end

  // ==========================================================
  // Register writes; thresholds are not guarded, software must
  // stop reception before changing them
  always @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      receive_control_q <= `RMRX_REG_RST;
      guide_high_lower_bound_q <= `RMRX_REG_RST;
      guide_high_upper_bound_q <= `RMRX_REG_RST;
      data_low_lower_bound_q <= `RMRX_REG_RST;
      data_low_upper_bound_q <= `RMRX_REG_RST;
      data_zero_high_lower_bound_q <= `RMRX_REG_RST;
      data_zero_high_upper_bound_q <= `RMRX_REG_RST;
      data_one_high_lower_bound_q <= `RMRX_REG_RST;
      data_one_high_upper_bound_q <= `RMRX_REG_RST;
      end_width_select_q <= `RMRX_REG_RST;
    end
    else
    begin
      if ((I_WR || I_BIT_WR) && I_ADDR == `RMRX_ADDR_CTRL)
        receive_control_q <= ctrl_wr_val;
      if (I_WR)
      begin
        case (I_ADDR)
          `RMRX_ADDR_GPHS: guide_high_lower_bound_q <= I_WDATA;
          `RMRX_ADDR_GPHL: guide_high_upper_bound_q <= I_WDATA;
          `RMRX_ADDR_DLS: data_low_lower_bound_q <= I_WDATA;
          `RMRX_ADDR_DLL: data_low_upper_bound_q <= I_WDATA;
          `RMRX_ADDR_DH0S: data_zero_high_lower_bound_q <= I_WDATA;
          `RMRX_ADDR_DH0L: data_zero_high_upper_bound_q <= I_WDATA;
          `RMRX_ADDR_DH1S: data_one_high_lower_bound_q <= I_WDATA;
          `RMRX_ADDR_DH1L: data_one_high_upper_bound_q <= I_WDATA;
          `RMRX_ADDR_ER: end_width_select_q <= I_WDATA;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Read data, registered; unmapped addresses read zero
  always @(posedge I_CLK)
  begin
    if (I_RESET)
      O_RDATA <= `RMRX_REG_RST;
    else if (I_RD)
    begin
      case (I_ADDR)
        `RMRX_ADDR_CTRL: O_RDATA <= receive_control_q;
        `RMRX_ADDR_GPHS: O_RDATA <= guide_high_lower_bound_q;
        `RMRX_ADDR_GPHL: O_RDATA <= guide_high_upper_bound_q;
        `RMRX_ADDR_DLS: O_RDATA <= data_low_lower_bound_q;
        `RMRX_ADDR_DLL: O_RDATA <= data_low_upper_bound_q;
        `RMRX_ADDR_DH0S: O_RDATA <= data_zero_high_lower_bound_q;
        `RMRX_ADDR_DH0L: O_RDATA <= data_zero_high_upper_bound_q;
        `RMRX_ADDR_DH1S: O_RDATA <= data_one_high_lower_bound_q;
        `RMRX_ADDR_DH1L: O_RDATA <= data_one_high_upper_bound_q;
        `RMRX_ADDR_ER: O_RDATA <= end_width_select_q;
        `RMRX_ADDR_SR: O_RDATA <= bit_shift_register_q;
        `RMRX_ADDR_SCR: O_RDATA <= valid_bit_count_q;
        `RMRX_ADDR_DR: O_RDATA <= byte_holding_register_q;
        default: O_RDATA <= `RMRX_REG_RST;
      endcase
    end
  end

  // ==========================================================
  // Width classification and next state; widths are judged on the
  // counter value held in the cycle of the edge
  always @*
  begin
    state_d = state_q;
    err_now = 1'b0;
    store_now = 1'b0;
    bit_now = 1'b0;
    guide_now = 1'b0;
    frame_now = 1'b0;
    cnt_restart = rise | fall;
    case (state_q)
      ST_IDLE:
        if (rise)
          state_d = ST_GUIDE;
      ST_GUIDE:
        if (fall)
        begin
          if (cnt_q >= guide_high_lower_bound_q && cnt_q < guide_high_upper_bound_q)
          begin
            guide_now = 1'b1;
            state_d = ST_DLOW;
          end
          else
            state_d = ST_IDLE;
        end
      ST_DLOW:
        if (rise)
        begin
          if (cnt_q < data_low_lower_bound_q)
          begin
            err_now = 1'b1;
            state_d = ST_GUIDE;
          end
          else
            state_d = ST_DHIGH;
        end
        else if (cnt_q >= data_low_upper_bound_q)
        begin
          cnt_restart = 1'b1;
          state_d = ST_ENDW;
        end
      ST_DHIGH:
        if (fall)
        begin
          if (cnt_q >= data_zero_high_lower_bound_q && cnt_q < data_zero_high_upper_bound_q)
          begin
            store_now = 1'b1;
            state_d = ST_DLOW;
          end
          else if (cnt_q >= data_one_high_lower_bound_q && cnt_q < data_one_high_upper_bound_q)
          begin
            store_now = 1'b1;
            bit_now = 1'b1;
            state_d = ST_DLOW;
          end
          else
          begin
            err_now = 1'b1;
            state_d = ST_IDLE;
          end
        end
        else if (cnt_q >= data_one_high_upper_bound_q)
        begin
          err_now = 1'b1;
          state_d = ST_IDLE;
        end
      ST_ENDW:
        if (rise)
        begin
          err_now = 1'b1;
          state_d = ST_GUIDE;
        end
        else if (cnt_q >= end_width_select_q)
        begin
          frame_now = 1'b1;
          state_d = ST_HALT;
        end
      ST_HALT:
        if (sr_read)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Receive state, width counter and edge history
  always @(posedge I_CLK)
  begin
    if (I_RESET || !receive_enable)
    begin
      state_q <= ST_IDLE;
      cnt_q <= `RMRX_REG_RST;
      level_prev_q <= 1'b0;
      err_armed_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      level_prev_q <= level;
      if (cnt_restart)
        cnt_q <= `RMRX_REG_RST;
      else if (tick && cnt_q != `RMRX_CNT_MAX)
        cnt_q <= cnt_q + 8'h01;
      if (guide_now)
        err_armed_q <= 1'b1;
      else if (err_now)
        err_armed_q <= 1'b0;
    end
  end

  // ==========================================================
  // Shift, count and holding registers
  always @(posedge I_CLK)
  begin
    if (I_RESET || !receive_enable)
    begin
      bit_shift_register_q <= `RMRX_REG_RST;
      valid_bit_count_q <= `RMRX_REG_RST;
      byte_holding_register_q <= `RMRX_REG_RST;
    end
    else if (err_now)
    begin
      bit_shift_register_q <= `RMRX_REG_RST;
      valid_bit_count_q <= `RMRX_REG_RST;
    end
    else if (store_now && valid_bit_count_q == `RMRX_BIT_LAST)
    begin
      byte_holding_register_q <= shifted;
      bit_shift_register_q <= `RMRX_REG_RST;
      valid_bit_count_q <= `RMRX_REG_RST;
    end
    else if (store_now)
    begin
      bit_shift_register_q <= shifted;
      valid_bit_count_q <= valid_bit_count_q + 8'h01;
    end
    else if (state_q == ST_HALT && sr_read)
    begin
      bit_shift_register_q <= `RMRX_REG_RST;
      valid_bit_count_q <= `RMRX_REG_RST;
    end
  end

  // ==========================================================
  // Event pulses, one cycle each
  always @(posedge I_CLK)
  begin
    if (I_RESET || !receive_enable)
    begin
      O_GUIDE_PULSE_EVENT <= 1'b0;
      O_BYTE_FULL_EVENT <= 1'b0;
      O_FRAME_END_EVENT <= 1'b0;
      O_RECEIVE_ERROR_EVENT <= 1'b0;
    end
    else
    begin
      O_GUIDE_PULSE_EVENT <= guide_now;
      O_BYTE_FULL_EVENT <= store_now && valid_bit_count_q == `RMRX_BIT_LAST;
      O_FRAME_END_EVENT <= frame_now;
      O_RECEIVE_ERROR_EVENT <= err_now & err_armed_q;
    end
  end

endmodule // rmrx_top

// file: testbench/rmrx_ir_model.sv
`timescale 1ns/1ps
// ====================
// IR line source, moves on falling clock edges
module rmrx_ir_model
(
  input wire i_clk,
  output logic o_pin = 1'b0
);
  int tk = 64; // Clocks per counter tick
  logic inv = 1'b0; // Drive the line inverted

  // Hold a level for n ticks
  task automatic hold(input logic l, input int n);
    @(negedge i_clk);
    o_pin = l ^ inv;
    repeat (n * tk - 1) @(negedge i_clk);
  endtask

  // Guide, bits first to last, closing low well past the end width
  task automatic frame(input logic [7:0] b, input int nb);
    hold(1'b1, 12);
    for (int k = 0; k < nb; k++)
    begin
      hold(1'b0, 4);
      hold(1'b1, b[k] ? 8 : 3);
    end
    hold(1'b0, 16);
  endtask
endmodule // rmrx_ir_model

// file: testbench/rmrx_top_assertions.sv
`timescale 1ns/1ps
`include "rmrx_consts.vh"
// ====================
// Port checks of the receiver
module rmrx_checker
(
  // Bus
  input wire I_CLK,
  input wire I_RESET,
  input wire [15:0] I_ADDR,
  input wire I_WR,
  input wire [7:0] I_WDATA,
  input wire I_BIT_WR,
  input wire [2:0] I_BIT_SEL,
  input wire I_BIT_VAL,
  input wire I_RD,
  input wire [7:0] O_RDATA,
  // Events
  input wire O_GUIDE_PULSE_EVENT,
  input wire O_BYTE_FULL_EVENT,
  input wire O_FRAME_END_EVENT,
  input wire O_RECEIVE_ERROR_EVENT
);
  reg en_q;
  reg [7:0] dh1l_q;
  reg [7:0] er_q;
  reg blk_q;
  reg halt_q;
  reg clr_q;
  // Decoded reads and data events
  wire rd_sr = I_RD && I_ADDR == `RMRX_ADDR_SR;
  wire rd_sc = rd_sr || (I_RD && I_ADDR == `RMRX_ADDR_SCR);
  wire ev = O_GUIDE_PULSE_EVENT || O_BYTE_FULL_EVENT || O_RECEIVE_ERROR_EVENT;

  // Mirrors; a disable counts as clearing, since it resets the receive side
  always @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      en_q <= 1'b0;
      dh1l_q <= 8'h00;
      er_q <= 8'h00;
      blk_q <= 1'b1;
      halt_q <= 1'b0;
      clr_q <= 1'b1;
    end
    else
    begin
      if (I_BIT_WR && I_ADDR == `RMRX_ADDR_CTRL && I_BIT_SEL == 3'h7)
        en_q <= I_BIT_VAL;
      else if (I_WR && I_ADDR == `RMRX_ADDR_CTRL)
        en_q <= I_WDATA[7];
      if (I_WR && I_ADDR == `RMRX_ADDR_DH1L)
        dh1l_q <= I_WDATA;
      if (I_WR && I_ADDR == `RMRX_ADDR_ER)
        er_q <= I_WDATA;
      blk_q <= !O_GUIDE_PULSE_EVENT && (blk_q || O_RECEIVE_ERROR_EVENT || !en_q);
      halt_q <= O_FRAME_END_EVENT || (halt_q && !rd_sr && en_q);
      clr_q <= !O_GUIDE_PULSE_EVENT && (clr_q || !en_q || (rd_sr && halt_q));
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);

  a_reset_clears: assert property ($fell(I_RESET) |-> O_RDATA == 8'h00 && !ev)
    else $error("outputs not clear after reset");
  a_ctrl_read: assert property (I_RD && I_ADDR == `RMRX_ADDR_CTRL |=>
    O_RDATA[7] == en_q && O_RDATA[3:2] == 2'b00) else $error("control read wrong");
  a_dh1l_read: assert property (I_RD && I_ADDR == `RMRX_ADDR_DH1L |=> O_RDATA == dh1l_q)
    else $error("upper bound read wrong");
  a_end_read: assert property (I_RD && I_ADDR == `RMRX_ADDR_ER |=> O_RDATA == er_q)
    else $error("end width read wrong");
  a_off_quiet: assert property (!en_q [*4] |-> !ev && !O_FRAME_END_EVENT)
    else $error("event while disabled");
  a_off_hold: assert property (I_RD && I_ADDR == `RMRX_ADDR_DR && !en_q && !$past(en_q)
    |=> O_RDATA == 8'h00) else $error("holding not cleared");
  a_err_once: assert property (O_RECEIVE_ERROR_EVENT |-> !blk_q)
    else $error("error without fresh guide");
  a_halt_quiet: assert property (halt_q |-> !ev)
    else $error("reception while halted");
  a_err_clear: assert property (rd_sc && blk_q |=> O_RDATA == 8'h00)
    else $error("shift or count kept after error");
  a_halt_clear: assert property (rd_sc && clr_q |=> O_RDATA == 8'h00)
    else $error("shift or count kept after read");
endmodule // rmrx_checker

bind rmrx_top rmrx_checker u_chk (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR),
  .I_WR(I_WR), .I_WDATA(I_WDATA), .I_BIT_WR(I_BIT_WR), .I_BIT_SEL(I_BIT_SEL),
  .I_BIT_VAL(I_BIT_VAL), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .O_GUIDE_PULSE_EVENT(O_GUIDE_PULSE_EVENT), .O_BYTE_FULL_EVENT(O_BYTE_FULL_EVENT),
  .O_FRAME_END_EVENT(O_FRAME_END_EVENT), .O_RECEIVE_ERROR_EVENT(O_RECEIVE_ERROR_EVENT));

// file: testbench/rmrx_top_tb.sv
`timescale 1ns/1ps
`include "rmrx_consts.vh"
// ====================
// Receiver bench
module rmrx_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic bwr = 1'b0;
  logic [2:0] bsel = 3'h0;
  logic bval = 1'b0;
  logic rd = 1'b0;
  logic sub = 1'b0;
  wire pin;
  wire [7:0] rdata;
  wire gp, full, fend, err;
  int errors = 0;
  int checks_done = 0;
  integer n_gp = 0;
  integer n_full = 0;
  integer n_end = 0;
  integer n_err = 0;
  // Windows in ticks: wide margins absorb the one-tick edge jitter
  logic [7:0] thr [9] = '{8'h08, 8'h10, 8'h02, 8'h06, 8'h02, 8'h05, 8'h06, 8'h0B, 8'h04};
  logic [7:0] cf [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hA0, 8'hC0, 8'h90};
  int tk [7] = '{64, 128, 256, 100, 128, 64, 64};

  // Clocks; the oscillator has a period of 100 clocks
  always #10 clk = ~clk;
  always #1000 sub = ~sub;

  rmrx_ir_model src (.i_clk(clk), .o_pin(pin));
  rmrx_top dut (.I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WR(wr), .I_WDATA(wdata),
    .I_BIT_WR(bwr), .I_BIT_SEL(bsel), .I_BIT_VAL(bval), .I_RD(rd), .O_RDATA(rdata),
    .I_IR_INPUT_PIN(pin), .I_SUB_CLK(sub), .O_GUIDE_PULSE_EVENT(gp),
    .O_BYTE_FULL_EVENT(full), .O_FRAME_END_EVENT(fend), .O_RECEIVE_ERROR_EVENT(err));

  // Count event pulses out of reset; an unknown event poisons its count
  always @(posedge clk)
  begin
    if (!rst)
    begin
      n_gp <= n_gp + gp;
      n_full <= n_full + full;
      n_end <= n_end + fend;
      n_err <= n_err + err;
    end
  end

  task automatic check_reg(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_cnt(input integer g, input integer e);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic bit_wr(input logic [2:0] s, input logic v);
    @(negedge clk);
    addr = `RMRX_ADDR_CTRL;
    bsel = s;
    bval = v;
    bwr = 1'b1;
    @(negedge clk);
    bwr = 1'b0;
  endtask

  // Read one register and compare
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check_reg(rdata, e);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int a = 16'hFF60; a <= 16'hFF6D; a++)
      rreg(a[15:0], 8'h00);
    wreg(`RMRX_ADDR_CTRL, 8'h73);
    rreg(`RMRX_ADDR_CTRL, 8'h73);
    bit_wr(3'h7, 1'b1);
    rreg(`RMRX_ADDR_CTRL, 8'hF3);
    bit_wr(3'h7, 1'b0);
    wreg(`RMRX_ADDR_CTRL, 8'h00);
    for (int i = 0; i < 9; i++)
      wreg(16'hFF61 + i[15:0], thr[i]);
    rreg(`RMRX_ADDR_DH1L, 8'h0B);
    rreg(`RMRX_ADDR_ER, 8'h04);
    wreg(`RMRX_ADDR_CTRL, 8'h80);
    src.frame(8'hA5, 8);
    check_cnt(n_full, 1);
    check_cnt(n_end, 1);
    rreg(`RMRX_ADDR_DR, 8'hA5);
    rreg(`RMRX_ADDR_SCR, 8'h00);
    rreg(`RMRX_ADDR_SR, 8'h00);
    // Three bits, then a guide sent while halted
    src.frame(8'h03, 3);
    src.frame(8'h00, 0);
    check_cnt(n_gp, 2);
    rreg(`RMRX_ADDR_SCR, 8'h03);
    rreg(`RMRX_ADDR_SR, 8'h60);
    rreg(`RMRX_ADDR_SR, 8'h00);
    // One good bit, then over-long highs; only the first one is an error
    src.hold(1'b1, 12);
    src.hold(1'b0, 4);
    src.hold(1'b1, 8);
    repeat (2)
    begin
      src.hold(1'b0, 4);
      src.hold(1'b1, 20);
    end
    src.hold(1'b0, 16);
    check_cnt(n_err, 1);
    check_cnt(n_gp, 3);
    rreg(`RMRX_ADDR_SCR, 8'h00);
    rreg(`RMRX_ADDR_SR, 8'h00);
    wreg(`RMRX_ADDR_CTRL, 8'h00);
    rreg(`RMRX_ADDR_DR, 8'h00);
    src.frame(8'h01, 1);
    check_cnt(n_gp, 3);
    // Each source, halving, noise width, polarity; short guide ignored first
    for (int i = 0; i < 7; i++)
    begin
      wreg(`RMRX_ADDR_CTRL, 8'h00);
      src.tk = tk[i];
      src.inv = cf[i][4];
      src.hold(1'b0, 4);
      wreg(`RMRX_ADDR_CTRL, cf[i]);
      src.hold(1'b1, 4);
      src.hold(1'b0, 8);
      src.frame(8'h00, 0);
      check_cnt(n_gp, 4 + i);
    end
    // Guide with a dip: the wide filter hides one tick, the narrow one splits on two
    for (int i = 0; i < 2; i++)
    begin
      wreg(`RMRX_ADDR_CTRL, 8'h00);
      src.inv = 1'b0;
      src.hold(1'b0, 4);
      wreg(`RMRX_ADDR_CTRL, i ? 8'h80 : 8'hC0);
      src.hold(1'b1, 5);
      src.hold(1'b0, 1 + i);
      src.hold(1'b1, 7);
      src.hold(1'b0, 16);
      check_cnt(n_gp, 11);
    end
    end_of_test();
  end

  // Watchdog, well past the expected run
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule // rmrx_top_tb
